/* inc/aarc_defs.svh */
`ifndef AARC_DEFS_SVH
`define AARC_DEFS_SVH

// converter word and field layout
`define AARC_CODE_W        18
`define AARC_RANGE_W       4
`define AARC_RANGE_UNI_BIT 3
`define AARC_PINFN_W       2

// reset values and the alarm pin function code
`define AARC_RANGE_RST     4'h0
`define AARC_REFDIS_RST    1'b0
`define AARC_PINFN_RST     2'h0
`define AARC_PINFN_ALARM   2'h1

// supply trip points in millivolts, kept for reference; the comparator sits outside
`define AARC_SUPPLY_LOW_MV  4700
`define AARC_SUPPLY_HIGH_MV 5300

// alarm flag word follows the packed struct: {in_act, in_trip, sup_act, sup_trip}
`define AARC_FLAG_W        4
`define AARC_FLAG_IN_ACT   3
`define AARC_FLAG_IN_TRIP  2
`define AARC_FLAG_SUP_ACT  1
`define AARC_FLAG_SUP_TRIP 0

`endif

/* inc/aarc_pkg.sv */
package aarc_pkg;
  `include "aarc_defs.svh"

  typedef logic [`AARC_CODE_W-1:0] aarc_code_t;

  // configuration that steers the block
  typedef struct packed {
    logic                      internal_ref_disable;
    logic                      input_alarm_disable;
    logic                      supply_alarm_disable;
    logic [`AARC_PINFN_W-1:0]  aux_output_pin_function;
    logic [`AARC_RANGE_W-1:0]  range_select;
    logic [`AARC_FLAG_W-1:0]   append_mask;
  } aarc_cfg_s;

  // programmed input thresholds and common hysteresis
  typedef struct packed {
    aarc_code_t high_th;
    aarc_code_t low_th;
    aarc_code_t hyst;
  } aarc_thr_s;

  typedef struct packed {
    logic in_act;
    logic in_trip;
    logic sup_act;
    logic sup_trip;
  } aarc_flags_s;
endpackage : aarc_pkg

/* logic/aarc_alarm_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - reference disable resets to zero, internal reference
// - disable set: reference pin input, else driven
// - results are unsigned 18-bit straight binary codes
// - alarm pin function only when field is 01b
// - input alarm above high or below low threshold
// - supply alarm on monitor crossing either trip point
// - both alarms enabled; each has disable bit
// - alarm sets active and tripped flags together
// - active flag recomputed at each conversion end
// - tripped flag cleared only by flag read
// - active flags update only at conversion completion
// - flags readable in any frame opened low
// - alarm pin high on supply or input alarm
// - selected flags appended to output data word
// - one flag register holds all flags
// - range field resets 0000; bit3 selects unipolar
// - high alarm clears at or below T-H-1
// - low alarm clears at or above T+H+1
`include "aarc_defs.svh"
module aarc_alarm_ctrl
  import aarc_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  // configuration writes from the register port
  input  wire logic                    cfg_we_i,
  input  wire aarc_pkg::aarc_cfg_s     cfg_i,
  input  wire aarc_pkg::aarc_thr_s     thr_i,
  // converter result, one-cycle pulse per finished conversion
  input  wire logic                    conv_done_i,
  input  wire aarc_pkg::aarc_code_t    conv_code_i,
  // supply comparator levels, asynchronous
  input  wire logic                    supply_low_i,
  input  wire logic                    supply_high_i,
  // frame and flag read
  input  wire logic                    convert_start_select_i,
  input  wire logic                    flag_read_i,
  // outputs
  output logic                         reference_io_pin_oe_o,
  output logic                         alarm_multifunction_pin_o,
  output logic                         alarm_multifunction_pin_oe_o,
  output aarc_pkg::aarc_flags_s        flags_o,
  output logic [`AARC_CODE_W+`AARC_FLAG_W-1:0] data_word_o,
  output logic                         range_unipolar_o,
  output logic [`AARC_RANGE_W-1:0]     range_select_o
);
  import aarc_pkg::*;

  aarc_cfg_s   cfg;       // written configuration
  aarc_cfg_s   cfg_live;  // configuration latched at a conversion end
  aarc_flags_s flags;
  logic        hi_alarm;
  logic        lo_alarm;
  logic [1:0]  sup_lo_sync;
  logic [1:0]  sup_hi_sync;
  logic [1:0]  cs_sync;
  logic        cs_q;      // third stage, only the edge detector reads it
  logic        conv_q;    // conversion end delayed to after the flag update
  aarc_code_t  code_q;    // last result, held for frames between conversions
  logic        sup_lo_q;
  logic        sup_hi_q;
  logic        sup_seen;
  logic        next_hi_alarm;
  logic        next_lo_alarm;
  logic        in_cond;
  logic [`AARC_CODE_W:0] hi_clr_lim;
  logic [`AARC_CODE_W:0] lo_clr_lim;

  // register port configuration, defaults selected internal ref and widest range
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cfg <= '0;
      cfg.internal_ref_disable <= `AARC_REFDIS_RST;
      cfg.range_select <= `AARC_RANGE_RST;
      cfg.aux_output_pin_function <= `AARC_PINFN_RST;
    end
    else if (cfg_we_i)
    begin
      cfg <= cfg_i;
    end
  end

  // reference and range changes apply from the next conversion so a result never mixes settings
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cfg_live <= '0;
      cfg_live.internal_ref_disable <= `AARC_REFDIS_RST;
      cfg_live.range_select <= `AARC_RANGE_RST;
    end
    else if (conv_done_i)
    begin
      cfg_live <= cfg;
    end
  end

  // two-flop synchronisers for the comparator and select pin
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      sup_lo_sync <= 2'h0;
      sup_hi_sync <= 2'h0;
      cs_sync     <= 2'h3;
      cs_q        <= 1'b1;
    end
    else
    begin
      sup_lo_sync <= {sup_lo_sync[0], supply_low_i};
      sup_hi_sync <= {sup_hi_sync[0], supply_high_i};
      cs_sync     <= {cs_sync[0], convert_start_select_i};
      cs_q        <= cs_sync[1];
    end
  end

  // any supply excursion between conversions is remembered until the next end
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      sup_lo_q <= 1'b0;
      sup_hi_q <= 1'b0;
      sup_seen <= 1'b0;
    end
    else
    begin
      sup_lo_q <= sup_lo_sync[1];
      sup_hi_q <= sup_hi_sync[1];
      // a crossing in the very cycle of the end still counts for the next result
      if (conv_done_i)
        sup_seen <= sup_lo_sync[1] | sup_hi_sync[1]
                    | (sup_lo_sync[1] != sup_lo_q) | (sup_hi_sync[1] != sup_hi_q);
      else if (sup_lo_sync[1] != sup_lo_q || sup_hi_sync[1] != sup_hi_q
               || sup_lo_sync[1] || sup_hi_sync[1])
        sup_seen <= 1'b1;
    end
  end

  // hysteresis limits, widened a bit so T-H-1 and T+H+1 cannot wrap
  always_comb
  begin
    hi_clr_lim = {1'b0, thr_i.high_th} - {1'b0, thr_i.hyst} - {{`AARC_CODE_W{1'b0}}, 1'b1};
    lo_clr_lim = {1'b0, thr_i.low_th} + {1'b0, thr_i.hyst} + {{`AARC_CODE_W{1'b0}}, 1'b1};
  end

  // input threshold alarms with hysteresis, codes compared unsigned
  always_comb
  begin
    next_hi_alarm = hi_alarm;
    next_lo_alarm = lo_alarm;
    if (conv_code_i > thr_i.high_th)
      next_hi_alarm = 1'b1;
    else if (!hi_clr_lim[`AARC_CODE_W] && {1'b0, conv_code_i} <= hi_clr_lim)
      next_hi_alarm = 1'b0;
    if (conv_code_i < thr_i.low_th)
      next_lo_alarm = 1'b1;
    else if (lo_clr_lim[`AARC_CODE_W] == 1'b0 && {1'b0, conv_code_i} >= lo_clr_lim)
      next_lo_alarm = 1'b0;
    in_cond = next_hi_alarm | next_lo_alarm;
  end

  // hysteresis state advances only with each result
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      hi_alarm <= 1'b0;
      lo_alarm <= 1'b0;
    end
    else if (conv_done_i)
    begin
      hi_alarm <= next_hi_alarm;
      lo_alarm <= next_lo_alarm;
    end
  end

  // active flags rebuilt at each end; tripped flags sticky, set beats read clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      flags <= '0;
    end
    else
    begin
      if (flag_read_i)
      begin
        flags.in_trip  <= 1'b0;
        flags.sup_trip <= 1'b0;
      end
      if (conv_done_i)
      begin
        flags.in_act  <= in_cond & ~cfg.input_alarm_disable;
        flags.sup_act <= sup_seen & ~cfg.supply_alarm_disable;
        if (in_cond && !cfg.input_alarm_disable)
          flags.in_trip <= 1'b1;
        if (sup_seen && !cfg.supply_alarm_disable)
          flags.sup_trip <= 1'b1;
      end
    end
  end

  // result kept and end strobe delayed so the snapshot sees the flags of this result
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      conv_q <= 1'b0;
      code_q <= '0;
    end
    else
    begin
      conv_q <= conv_done_i;
      if (conv_done_i)
        code_q <= conv_code_i;
    end
  end

  // flag register and data word snapshot at the frame-opening falling select edge and one cycle after each conversion end
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      flags_o     <= '0;
      data_word_o <= '0;
    end
    else if ((cs_q && !cs_sync[1]) || conv_q)
    begin
      flags_o     <= flags;
      data_word_o <= {code_q, flags & cfg.append_mask};
    end
  end

  // pins and range outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      reference_io_pin_oe_o        <= 1'b1;
      alarm_multifunction_pin_o    <= 1'b0;
      alarm_multifunction_pin_oe_o <= 1'b0;
      range_unipolar_o             <= 1'b0;
      range_select_o               <= `AARC_RANGE_RST;
    end
    else
    begin
      reference_io_pin_oe_o <= ~cfg_live.internal_ref_disable;
      alarm_multifunction_pin_oe_o <= (cfg.aux_output_pin_function == `AARC_PINFN_ALARM);
      alarm_multifunction_pin_o <= (cfg.aux_output_pin_function == `AARC_PINFN_ALARM)
                                   & (flags.in_act | flags.sup_act);
      range_select_o   <= cfg_live.range_select;
      range_unipolar_o <= cfg_live.range_select[`AARC_RANGE_UNI_BIT];
    end
  end

  // the pin follows the active flags one cycle later
  a_pin_follows_flags : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cfg.aux_output_pin_function == `AARC_PINFN_ALARM && (flags.in_act || flags.sup_act))
    |=> alarm_multifunction_pin_o)
    else $error("alarm pin low while an active flag is set");
  a_trip_holds : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (flags.in_trip && !flag_read_i) |=> flags.in_trip)
    else $error("input tripped flag cleared without a read");
  a_flags_at_end : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !conv_done_i |=> $stable(flags.in_act) && $stable(flags.sup_act))
    else $error("active flag changed outside a conversion end");
  a_disable_input : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (conv_done_i && cfg.input_alarm_disable) |=> !flags.in_act)
    else $error("disabled input alarm set its active flag");
  a_high_sets : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (conv_done_i && conv_code_i > thr_i.high_th && !cfg.input_alarm_disable)
    |=> flags.in_act && flags.in_trip)
    else $error("high threshold crossing missed");
  a_ref_dir : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 reference_io_pin_oe_o == !$past(cfg_live.internal_ref_disable))
    else $error("reference pin direction wrong");
  a_pin_off : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cfg.aux_output_pin_function != `AARC_PINFN_ALARM) |=> !alarm_multifunction_pin_oe_o)
    else $error("pin driven as alarm in another function");
  a_trip_set : assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(flags.sup_act) |-> flags.sup_trip)
    else $error("supply active flag set without tripped flag");
endmodule : aarc_alarm_ctrl

/* bench/aarc_host_model.sv */
`timescale 1ns/100ps
// host side of the frame and flag-read lines
module aarc_host_model
(
  // clock
  input  wire logic clk_sys_i,
  // lines towards the block
  output logic      convert_start_select_o,
  output logic      flag_read_o
);
  // select idles high between frames
  initial
  begin
    convert_start_select_o = 1'b1;
    flag_read_o            = 1'b0;
  end

  // held low long enough to pass the sync stages
  task automatic open_frame();
    @(posedge clk_sys_i) convert_start_select_o <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    convert_start_select_o <= 1'b1;
  endtask : open_frame

  // register read, one-cycle pulse
  task automatic read_flags();
    @(posedge clk_sys_i) flag_read_o <= 1'b1;
    @(posedge clk_sys_i) flag_read_o <= 1'b0;
  endtask : read_flags
endmodule : aarc_host_model

/* bench/aarc_alarm_ctrl_tb.sv */
`timescale 1ns/100ps
module aarc_alarm_ctrl_tb;
  import aarc_pkg::*;
  logic        clk_sys_i, rstn_i, cfg_we_i, conv_done_i, sup_lo, sup_hi, sel, frd;
  aarc_cfg_s   cfg_i;
  aarc_thr_s   thr_i;
  aarc_code_t  conv_code_i;
  logic        ref_oe, pin, pin_oe, uni;
  aarc_flags_s flags;
  logic [21:0] word;
  logic [3:0]  rng;
  int          n_fail, checks;

  aarc_alarm_ctrl u_aarc_alarm_ctrl (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .cfg_we_i(cfg_we_i), .cfg_i(cfg_i), .thr_i(thr_i), .conv_done_i(conv_done_i),
    .conv_code_i(conv_code_i), .supply_low_i(sup_lo), .supply_high_i(sup_hi),
    .convert_start_select_i(sel), .flag_read_i(frd), .reference_io_pin_oe_o(ref_oe),
    .alarm_multifunction_pin_o(pin), .alarm_multifunction_pin_oe_o(pin_oe),
    .flags_o(flags), .data_word_o(word), .range_unipolar_o(uni), .range_select_o(rng));
  aarc_host_model u_aarc_host_model (.clk_sys_i(clk_sys_i),
    .convert_start_select_o(sel), .flag_read_o(frd));

  // free-running clock, 4 ns period
  always #2 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // mask all ones so the data word carries every flag
  task automatic set_cfg(input logic rd, ia, sa, input logic [1:0] fn, input logic [3:0] rg);
    @(posedge clk_sys_i) cfg_we_i <= 1'b1;
    cfg_i <= '{rd, ia, sa, fn, rg, 4'hF};
    @(posedge clk_sys_i) cfg_we_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : set_cfg

  // one finished conversion, then flags, word and pin are judged
  task automatic conv(input aarc_code_t c, input logic [3:0] f, input logic p);
    @(posedge clk_sys_i) conv_done_i <= 1'b1;
    conv_code_i <= c;
    @(posedge clk_sys_i) conv_done_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(flags, f, "flags");
    chk(word, {c, f}, "data word");
    chk(pin, p, "alarm pin");
  endtask : conv

  task automatic t_reset();
    chk(ref_oe, 1, "ref oe");
    chk({pin, pin_oe, flags, word, rng, uni}, 0, "reset outs");
    $display("test reset done");
  endtask : t_reset

  task automatic t_ref();
    for (int fn = 0; fn < 4; fn++)
    begin
      set_cfg(1'b0, 1'b0, 1'b0, fn[1:0], 4'h0);
      chk(pin_oe, fn == 1, "pin fn");
    end
    set_cfg(1'b1, 1'b0, 1'b0, 2'h1, 4'h8);
    chk({ref_oe, rng}, 5'h10, "before conv");
    conv(18'h00032, 4'h0, 1'b0);
    chk({ref_oe, rng, uni}, 6'h11, "after conv");
    set_cfg(1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
    conv(18'h00032, 4'h0, 1'b0);
    chk(ref_oe, 1, "ref back");
    $display("test reference done");
  endtask : t_ref

  task automatic t_input();
    conv(18'h00064, 4'h0, 1'b0);
    conv(18'h0000A, 4'h0, 1'b0);
    conv(18'h00065, 4'hC, 1'b1);
    conv(18'h0005F, 4'hC, 1'b1);
    conv(18'h0005E, 4'h4, 1'b0);
    u_aarc_host_model.read_flags();
    u_aarc_host_model.open_frame();
    chk(flags, 0, "after read");
    conv(18'h00009, 4'hC, 1'b1);
    conv(18'h0000F, 4'hC, 1'b1);
    conv(18'h00010, 4'h4, 1'b0);
    u_aarc_host_model.read_flags();
    set_cfg(1'b0, 1'b1, 1'b0, 2'h1, 4'h0);
    conv(18'h000C8, 4'h0, 1'b0);
    set_cfg(1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
    conv(18'h000C8, 4'hC, 1'b1);
    u_aarc_host_model.read_flags();
    conv(18'h00032, 4'h0, 1'b0);
    $display("test input alarm done");
  endtask : t_input

  task automatic t_supply();
    @(posedge clk_sys_i) sup_lo <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    conv(18'h00032, 4'h3, 1'b1);
    @(posedge clk_sys_i) sup_lo <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    conv(18'h00032, 4'h3, 1'b1);
    conv(18'h00032, 4'h1, 1'b0);
    set_cfg(1'b0, 1'b0, 1'b1, 2'h1, 4'h0);
    u_aarc_host_model.read_flags();
    @(posedge clk_sys_i) sup_hi <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    conv(18'h00032, 4'h0, 1'b0);
    // high trip point with the supply alarm enabled again
    set_cfg(1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
    conv(18'h00032, 4'h3, 1'b1);
    // another pin function: alarm pin released although a flag is active
    set_cfg(1'b0, 1'b0, 1'b0, 2'h2, 4'h0);
    chk({pin, pin_oe}, 0, "pin off in other function");
    $display("test supply alarm done");
  endtask : t_supply

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // thresholds: high 100, low 10, hysteresis 5
  initial
  begin
    clk_sys_i   = 1'b0;
    rstn_i      = 1'b0;
    cfg_we_i    = 1'b0;
    cfg_i       = '0;
    thr_i       = '{18'h00064, 18'h0000A, 18'h00005};
    conv_done_i = 1'b0;
    conv_code_i = '0;
    sup_lo      = 1'b0;
    sup_hi      = 1'b0;
    n_fail      = 0;
    checks      = 0;
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    t_reset();
    t_ref();
    t_input();
    t_supply();
    stop_test();
  end
endmodule : aarc_alarm_ctrl_tb
